// [common/gate_if.sv]
`timescale 1ns/1ps
interface gate_if;
  logic [3:0] data;
  logic [7:0] term1;
  logic [7:0] term2;
  logic [7:0] term3;
  logic [2:0] invert;
  logic [2:0] gate;

  modport core (output data, term1, term2, term3, invert, input gate);
  modport comb (input data, term1, term2, term3, invert, output gate);
endinterface

// [common/gate_sel_pkg.sv]
// Operation
// [R1] Gate 1 true terms: bits 7,5,3,1.
// [R2] Gate 1 negated terms: bits 6,4,2,0.
// [R3] Gate 2 true terms: bits 7,5,3,1.
// [R4] Gate 2 negated terms: bits 6,4,2,0.
// [R5] Gate 3 true terms: bits 7,5,3,1.
// [R6] Gate 3 negated terms: bits 6,4,2,0.
// [R7] Term-select registers fully readable and writable.
// [R8] Per-gate invert bit flips gate output.
// [R9] Data 1 picked from eight inputs by code.
// [R10] Enabled terms ORed; none enabled gives zero.
package gate_sel_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W         = 8;
  localparam logic [7:0]  OFS_GATE1_TERM = 8'h00;
  localparam logic [7:0]  OFS_GATE2_TERM = 8'h04;
  localparam logic [7:0]  OFS_GATE3_TERM = 8'h08;
  localparam logic [7:0]  OFS_POLARITY   = 8'h0C;
  localparam logic [7:0]  OFS_DATA1_SEL  = 8'h10;
  localparam logic [7:0]  OFS_STATUS     = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          D4_TRUE_BIT    = 7;
  localparam int          D4_NEG_BIT     = 6;
  localparam int          D3_TRUE_BIT    = 5;
  localparam int          D3_NEG_BIT     = 4;
  localparam int          D2_TRUE_BIT    = 3;
  localparam int          D2_NEG_BIT     = 2;
  localparam int          D1_TRUE_BIT    = 1;
  localparam int          D1_NEG_BIT     = 0;
  localparam int          POL_G1_BIT     = 0;
  localparam int          POL_G2_BIT     = 1;
  localparam int          POL_G3_BIT     = 2;
  localparam int          SEL_D1_LSB     = 0;
  localparam int          SEL_D1_W       = 3;
  localparam int          STAT_GATE_LSB  = 0;
  localparam int          STAT_DATA_LSB  = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  TERM_RST       = 8'h00;
  localparam logic [2:0]  POL_RST        = 3'h0;
  localparam logic [2:0]  SEL_RST        = 3'h0;
  localparam logic [31:0] WORD_RST       = 32'h0000_0000;

endpackage

// [hw/gate_combine.sv]
`timescale 1ns/1ps
module gate_combine (
  gate_if.comb g
);

  // ----------------------------------------------------------------
  // Term gating
  // ----------------------------------------------------------------
  // Each data input owns an adjacent pair of select bits: the odd bit admits
  // the true copy, the even bit the inverted copy.
  function automatic logic gate_sum(input logic [7:0] sel, input logic [3:0] d);
    logic [7:0] terms;
    terms = 8'h00;
    for (int i = 0; i < 4; i++) begin
      terms[2*i+1] = d[i];
      terms[2*i]   = ~d[i];
    end
    return |(sel & terms);
  endfunction

  // ----------------------------------------------------------------
  // Gates with polarity
  // ----------------------------------------------------------------
  assign g.gate[0] = gate_sum(g.term1, g.data) ^ g.invert[0]; // R1 R2 R8 R10
  assign g.gate[1] = gate_sum(g.term2, g.data) ^ g.invert[1]; // R3 R4 R8 R10
  assign g.gate[2] = gate_sum(g.term3, g.data) ^ g.invert[2]; // R5 R6 R8 R10

endmodule

// [hw/gate_term_select.sv]
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
module gate_term_select (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  cell_inputs,
  input  wire logic        data_two_in,
  input  wire logic        data_three_in,
  input  wire logic        data_four_in,
  output logic             gate_one_output,
  output logic             gate_two_output,
  output logic             gate_three_output
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]  gate1_term_select;
  logic [7:0]  gate2_term_select;
  logic [7:0]  gate3_term_select;
  logic [2:0]  gate_invert;
  logic [2:0]  data_one_source_select;
  logic [10:0] pin_meta;
  logic [10:0] pin_sync;
  logic        data_one;
  logic [31:0] next_prdata;
  logic        setup_phase;
  logic        access_done;

  gate_if cif ();

  gate_combine u_combine (
    .g (cif.comb)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic addr_ok(input logic [7:0] a);
    if (a == gate_sel_pkg::OFS_GATE1_TERM) begin
      return 1'b1;
    end else if (a == gate_sel_pkg::OFS_GATE2_TERM) begin
      return 1'b1;
    end else if (a == gate_sel_pkg::OFS_GATE3_TERM) begin
      return 1'b1;
    end else if (a == gate_sel_pkg::OFS_POLARITY) begin
      return 1'b1;
    end else if (a == gate_sel_pkg::OFS_DATA1_SEL) begin
      return 1'b1;
    end else if (a == gate_sel_pkg::OFS_STATUS) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Cell inputs and data 2..4 arrive from other logic or pins, so every bit
  // passes two flops before any gate looks at it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_meta <= 11'h000;
      pin_sync <= 11'h000;
    end else begin
      pin_meta <= {data_four_in, data_three_in, data_two_in, cell_inputs};
      pin_sync <= pin_meta;
    end
  end

  assign data_one = pin_sync[data_one_source_select]; // R9

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // The stored selections are cleared at reset so that the gates never run
  // from unknown state; software is expected to load them before use.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gate1_term_select      <= gate_sel_pkg::TERM_RST;
      gate2_term_select      <= gate_sel_pkg::TERM_RST;
      gate3_term_select      <= gate_sel_pkg::TERM_RST;
      gate_invert            <= gate_sel_pkg::POL_RST;
      data_one_source_select <= gate_sel_pkg::SEL_RST;
    end else if (access_done && pwrite) begin
      if (paddr == gate_sel_pkg::OFS_GATE1_TERM) begin
        gate1_term_select <= pwdata[7:0]; // R7
      end else if (paddr == gate_sel_pkg::OFS_GATE2_TERM) begin
        gate2_term_select <= pwdata[7:0]; // R7
      end else if (paddr == gate_sel_pkg::OFS_GATE3_TERM) begin
        gate3_term_select <= pwdata[7:0]; // R7
      end else if (paddr == gate_sel_pkg::OFS_POLARITY) begin
        gate_invert <= pwdata[2:0]; // R8
      end else if (paddr == gate_sel_pkg::OFS_DATA1_SEL) begin
        data_one_source_select <= pwdata[gate_sel_pkg::SEL_D1_LSB +: gate_sel_pkg::SEL_D1_W]; // R9
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    next_prdata = gate_sel_pkg::WORD_RST;
    if (paddr == gate_sel_pkg::OFS_GATE1_TERM) begin
      next_prdata[7:0] = gate1_term_select; // R7
    end else if (paddr == gate_sel_pkg::OFS_GATE2_TERM) begin
      next_prdata[7:0] = gate2_term_select; // R7
    end else if (paddr == gate_sel_pkg::OFS_GATE3_TERM) begin
      next_prdata[7:0] = gate3_term_select; // R7
    end else if (paddr == gate_sel_pkg::OFS_POLARITY) begin
      next_prdata[2:0] = gate_invert;
    end else if (paddr == gate_sel_pkg::OFS_DATA1_SEL) begin
      next_prdata[gate_sel_pkg::SEL_D1_LSB +: gate_sel_pkg::SEL_D1_W] = data_one_source_select;
    end else if (paddr == gate_sel_pkg::OFS_STATUS) begin
      next_prdata[gate_sel_pkg::STAT_GATE_LSB +: 3] = {gate_three_output, gate_two_output, gate_one_output};
      next_prdata[gate_sel_pkg::STAT_DATA_LSB +: 4] = cif.data;
    end
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  // Answers are registered in the setup cycle, so every access takes exactly
  // one access cycle and the outputs stay glitch free.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= gate_sel_pkg::WORD_RST;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase && !addr_ok(paddr);
      if (setup_phase) begin
        prdata <= pwrite ? gate_sel_pkg::WORD_RST : next_prdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Gate outputs
  // ----------------------------------------------------------------
  assign cif.data   = {pin_sync[10], pin_sync[9], pin_sync[8], data_one};
  assign cif.term1  = gate1_term_select;
  assign cif.term2  = gate2_term_select;
  assign cif.term3  = gate3_term_select;
  assign cif.invert = gate_invert;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gate_one_output   <= 1'b0;
      gate_two_output   <= 1'b0;
      gate_three_output <= 1'b0;
    end else begin
      gate_one_output   <= cif.gate[0]; // R1 R2
      gate_two_output   <= cif.gate[1]; // R3 R4
      gate_three_output <= cif.gate[2]; // R5 R6
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence apb_setup(logic [7:0] a, logic w);
    psel && !penable && (pwrite == w) && (paddr == a);
  endsequence

  sequence apb_access;
    psel && penable && pready;
  endsequence

  g1_true_term_a : assert property ( // R1
    (gate1_term_select == 8'h80) && !gate_invert[0] && pin_sync[10] |=> gate_one_output)
    else $error("gate one ignored data four true term");

  g1_neg_term_a : assert property ( // R2
    (gate1_term_select == 8'h01) && !gate_invert[0] && !data_one |=> gate_one_output)
    else $error("gate one ignored data one negated term");

  g2_true_term_a : assert property ( // R3
    (gate2_term_select == 8'h08) && !gate_invert[1] |=> gate_two_output == $past(pin_sync[8]))
    else $error("gate two does not follow data two");

  g2_neg_term_a : assert property ( // R4
    (gate2_term_select == 8'h40) && !gate_invert[1] |=> gate_two_output != $past(pin_sync[10]))
    else $error("gate two does not invert data four");

  g3_true_term_a : assert property ( // R5
    (gate3_term_select == 8'h20) && !gate_invert[2] |=> gate_three_output == $past(pin_sync[9]))
    else $error("gate three does not follow data three");

  g3_neg_term_a : assert property ( // R6
    (gate3_term_select == 8'h04) && !gate_invert[2] |=> gate_three_output != $past(pin_sync[8]))
    else $error("gate three does not invert data two");

  term_write_a : assert property ( // R7
    apb_setup(gate_sel_pkg::OFS_GATE2_TERM, 1'b1) ##1 apb_access |=> gate2_term_select == $past(pwdata[7:0]))
    else $error("gate two select write lost");

  term_read_a : assert property ( // R7
    apb_setup(gate_sel_pkg::OFS_GATE3_TERM, 1'b0) |=> pready && (prdata[7:0] == $past(gate3_term_select)))
    else $error("gate three select read back wrong");

  gate_invert_a : assert property ( // R8
    (gate1_term_select == 8'h00) && gate_invert[0] |=> gate_one_output)
    else $error("gate one polarity not applied");

  data_one_sel_a : assert property ( // R9
    (gate1_term_select == 8'h02) && !gate_invert[0]
      |=> gate_one_output == $past(pin_sync[data_one_source_select]))
    else $error("data one source select wrong");

  empty_gate_a : assert property ( // R10
    ((gate3_term_select == 8'h00) && !gate_invert[2]) [*2] |-> ##1 !gate_three_output)
    else $error("gate three high with no term");

endmodule

// [tb/logic_cell_gate_term_select_test.sv]
`timescale 1ns/1ps
module logic_cell_gate_term_select_test;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  cell_inputs;
  logic        data_two_in;
  logic        data_three_in;
  logic        data_four_in;
  logic        gate_one_output;
  logic        gate_two_output;
  logic        gate_three_output;
  logic [2:0]  gates;
  logic [31:0] rd;
  logic        err;
  logic [3:0]  dv;
  logic [2:0]  expv;
  int          bad_count;
  int          tests_run;

  assign gates = {gate_three_output, gate_two_output, gate_one_output};

  gate_term_select u_gate_term_select (
    .clk               (clk),
    .rst_n             (rst_n),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .cell_inputs       (cell_inputs),
    .data_two_in       (data_two_in),
    .data_three_in     (data_three_in),
    .data_four_in      (data_four_in),
    .gate_one_output   (gate_one_output),
    .gate_two_output   (gate_two_output),
    .gate_three_output (gate_three_output)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One APB transfer; an idle cycle follows so no signal is driven twice in one step.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      $display("Error at %0t: pready timeout got %h expected %h", $time, pready, 1'b1);
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Inputs pass two sync flops and an output flop, so four edges is enough to settle.
  task automatic set_data(input logic [7:0] cells, input logic [2:0] hi);
    cell_inputs   <= cells;
    data_two_in   <= hi[0];
    data_three_in <= hi[1];
    data_four_in  <= hi[2];
    repeat (4) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    bad_count = 0;
    tests_run = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    cell_inputs = 8'h00;
    data_two_in = 1'b0;
    data_three_in = 1'b0;
    data_four_in = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);

    for (int g = 0; g < 3; g++) begin
      apb(1'b0, gate_sel_pkg::OFS_GATE1_TERM + 8'(4 * g), 32'h0000_0000);
      check(rd, 32'h0000_0000);
      apb(1'b1, gate_sel_pkg::OFS_GATE1_TERM + 8'(4 * g), 32'hFFFF_FF00 | 32'(8'h5A + 8'(g)));
      apb(1'b0, gate_sel_pkg::OFS_GATE1_TERM + 8'(4 * g), 32'h0000_0000);
      check(rd, 32'(8'h5A + 8'(g)));
      check({31'h0, err}, 32'h0000_0000);
    end
    apb(1'b1, 8'h18, 32'h0000_00FF);
    check({31'h0, err}, 32'h0000_0001);
    apb(1'b0, 8'h18, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
    $display("Test registers done");

    for (int g = 0; g < 3; g++) begin
      apb(1'b1, gate_sel_pkg::OFS_GATE1_TERM + 8'(4 * g), 32'h0000_0000);
    end
    apb(1'b1, gate_sel_pkg::OFS_POLARITY, 32'h0000_0000);
    // Only the selected data input differs from the rest, so a misrouted term shows up.
    for (int g = 0; g < 3; g++) begin
      for (int b = 0; b < 8; b++) begin
        apb(1'b1, gate_sel_pkg::OFS_GATE1_TERM + 8'(4 * g), 32'h0000_0001 << b);
        for (int d = 0; d < 2; d++) begin
          dv = (d == 1) ? (4'b0001 << (b / 2)) : ~(4'b0001 << (b / 2));
          set_data({8{dv[0]}}, dv[3:1]);
          expv = 3'b000;
          expv[g] = b[0] ? dv[b / 2] : ~dv[b / 2];
          check({29'h0, gates}, {29'h0, expv});
        end
      end
      apb(1'b1, gate_sel_pkg::OFS_GATE1_TERM + 8'(4 * g), 32'h0000_0000);
    end
    $display("Test term routing done");

    // Inversion is loaded while every term is still off, so an empty gate with its invert bit set must read high.
    apb(1'b1, gate_sel_pkg::OFS_POLARITY, 32'h0000_0005);
    apb(1'b0, gate_sel_pkg::OFS_POLARITY, 32'h0000_0000);
    check(rd, 32'h0000_0005);
    check({29'h0, gates}, 32'h0000_0005);
    apb(1'b1, gate_sel_pkg::OFS_GATE1_TERM, 32'h0000_00FF);
    apb(1'b1, gate_sel_pkg::OFS_GATE2_TERM, 32'h0000_0088);
    set_data(8'h00, 3'b000);
    check({29'h0, gates}, 32'h0000_0004);
    set_data(8'h00, 3'b001);
    check({29'h0, gates}, 32'h0000_0006);
    apb(1'b1, gate_sel_pkg::OFS_POLARITY, 32'h0000_0000);
    repeat (2) @(posedge clk);
    check({29'h0, gates}, 32'h0000_0003);
    apb(1'b0, gate_sel_pkg::OFS_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0013);
    check({31'h0, err}, 32'h0000_0000);
    $display("Test polarity done");

    apb(1'b1, gate_sel_pkg::OFS_GATE1_TERM, 32'h0000_0002);
    apb(1'b1, gate_sel_pkg::OFS_GATE2_TERM, 32'h0000_0000);
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, gate_sel_pkg::OFS_DATA1_SEL, 32'(s));
      set_data(8'h01 << s, 3'b000);
      check({31'h0, gate_one_output}, 32'h0000_0001);
      set_data(~(8'h01 << s), 3'b000);
      check({31'h0, gate_one_output}, 32'h0000_0000);
    end
    apb(1'b0, gate_sel_pkg::OFS_DATA1_SEL, 32'h0000_0000);
    check(rd, 32'h0000_0007);
    $display("Test data one select done");
    close_out();
  end
endmodule
